//--- verilog/lprs_pkg.sv
package lprs_pkg;
	// ========================================
	// register map (byte addresses)
	localparam logic [15:0] BREAK_STATUS_IDX = 16'hfe00;
	localparam logic [15:0] RESET_CAUSE_IDX = 16'hfe01;
	localparam logic [15:0] BREAK_FLAG_CTRL_IDX = 16'hfe03;
	localparam logic [17:0] BREAK_STATUS_ADDR = {BREAK_STATUS_IDX, 2'b00};
	localparam logic [17:0] RESET_CAUSE_ADDR = {RESET_CAUSE_IDX, 2'b00};
	localparam logic [17:0] BREAK_FLAG_CTRL_ADDR = {BREAK_FLAG_CTRL_IDX, 2'b00};
	localparam logic [17:0] LP_CTRL_ADDR = 18'h3f810;
	localparam logic [17:0] LP_STATUS_ADDR = 18'h3f814;
	localparam int ADDR_W = 18;
	// ========================================
	// field positions
	localparam int BES_WAIT_BIT = 1;
	localparam int RC_POR_BIT = 7;
	localparam int RC_PIN_BIT = 6;
	localparam int RC_WDOG_BIT = 5;
	localparam int RC_ILLEGAL_OPCODE_FLAG_BIT = 4;
	localparam int RC_ILLEGAL_ADDR_FLAG_BIT = 3;
	localparam int RC_MON_BIT = 2;
	localparam int RC_LVI_BIT = 1;
	localparam int BCE_BIT = 7;
	localparam int CFG_SSR_BIT = 0;
	localparam int CFG_WDD_BIT = 1;
	localparam logic [7:0] RC_POR_VALUE = 8'h80;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] VECTOR_BLANK = 8'hff;
	// ========================================
	// recovery timing in crystal clock cycles
	localparam int LONG_RECOVERY = 4096;
	localparam int SHORT_RECOVERY = 32;
	localparam int CRYSTAL_DIV = 2;
	typedef enum logic [1:0] {LPRS_RUN, LPRS_WAIT, LPRS_STOP, LPRS_RECOVER} lprs_state_e;
endpackage

//--- verilog/lprs_recovery_counter.sv
`timescale 1ns/100ps
module lprs_recovery_counter #(
	parameter int LONG_CYCLES = lprs_pkg::LONG_RECOVERY,
	parameter int SHORT_CYCLES = lprs_pkg::SHORT_RECOVERY
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic hold_clear,
	input wire logic tick,
	input wire logic short_sel,
	output logic done
);
	import lprs_pkg::*;
	localparam int CW = $clog2(LONG_CYCLES + 1);
	initial
	begin
		if (SHORT_CYCLES < 1 || LONG_CYCLES < SHORT_CYCLES)
			$error("recovery counts out of range");
	end
	logic [CW-1:0] count_reg;
	logic [CW-1:0] target;
	assign target = short_sel ? CW'(SHORT_CYCLES) : CW'(LONG_CYCLES);
	// ========================================
	// held clear until recovery, then counts crystal ticks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else if (hold_clear)
			count_reg <= '0;
		else if (tick && count_reg < target)
			count_reg <= count_reg + CW'(1);
	end
	assign done = !hold_clear && count_reg >= target;
endmodule

//--- verilog/lprs_ctrl.sv
// Register access over APB was left to the implementer.
`timescale 1ns/100ps
// Contract
// [RQ1] wait or stop execution clears the cpu interrupt mask bit
// [RQ2] wait mode gates cpu clock off, peripheral clock keeps running
// [RQ3] enabled interrupt in wait wakes cpu, stacking one cycle later
// [RQ4] reset or emulation break exits wait; break sets break-exited-wait flag
// [RQ5] watchdog stays enabled in wait when watchdog disable is zero
// [RQ6] stop entry clears recovery counter and gates both clock outputs
// [RQ7] interrupt exits stop; stacking only after full recovery time
// [RQ8] any reset forces exit from stop
// [RQ9] recovery is 4096 crystal cycles, or 32 when short recovery set
// [RQ10] recovery counter held clear from stop until recovery begins
// [RQ11] software should clear short recovery with external crystal
// [RQ12] break status reads one when break ended wait mode
// [RQ13] reading reset cause status clears all its flags
// [RQ14] power-on reset sets power-on flag and clears the others; code also sets flags of other resets in the same cycle
// [RQ15] other resets set only their own flag, others kept
// [RQ16] flags for pin, watchdog, illegal opcode, low voltage, illegal fetch
// [RQ17] monitor-entry flag set on blank reset vector without test voltage
// [RQ18] break-time flag clears allowed only while break clear enable set
// [RQ19] flags cleared in break stay cleared; two-step clears stay protected
// [RQ20] registers are eight bits; unimplemented bits read zero
module lprs_ctrl #(
	parameter int LONG_CYCLES = lprs_pkg::LONG_RECOVERY,
	parameter int SHORT_CYCLES = lprs_pkg::SHORT_RECOVERY,
	parameter int XTAL_DIV = lprs_pkg::CRYSTAL_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lprs_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic module_irq,
	input wire logic break_irq,
	input wire logic emulation_mode,
	input wire logic break_state,
	input wire logic por_event,
	input wire logic pin_reset_event,
	input wire logic watchdog_reset_event,
	input wire logic illegal_opcode_event,
	input wire logic illegal_fetch_event,
	input wire logic low_voltage_event,
	input wire logic monitor_entry_event,
	input wire logic [7:0] vector_high,
	input wire logic [7:0] vector_low,
	input wire logic irq_at_test_voltage,
	input wire logic flag_clear_request,
	output logic cpu_clock_en,
	output logic periph_clock_en,
	output logic core_clock_out,
	output logic crystal_clock_out,
	output logic clear_int_mask,
	output logic stack_start,
	output logic watchdog_enable,
	output logic flag_clear_allow
);
	import lprs_pkg::*;
	initial
	begin
		if (XTAL_DIV < 1)
			$error("crystal divider must be at least one");
	end
	// ========================================
	// apb decode
	logic wr_en;
	logic rd_en;
	logic hit;
	assign hit = paddr == BREAK_STATUS_ADDR || paddr == RESET_CAUSE_ADDR
		|| paddr == BREAK_FLAG_CTRL_ADDR || paddr == LP_CTRL_ADDR || paddr == LP_STATUS_ADDR;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	// ========================================
	// state
	lprs_state_e state_reg;
	logic [7:0] reset_cause_reg;
	logic break_wait_reg;
	logic break_clear_en_reg;
	logic [1:0] config_reg;
	logic stack_reg;
	logic mask_clr_reg;
	logic rec_done;
	logic xtal_tick;
	logic [15:0] div_reg;
	logic any_reset;
	assign any_reset = por_event || pin_reset_event || watchdog_reset_event
		|| illegal_opcode_event || illegal_fetch_event || low_voltage_event || monitor_entry_event;
	// ========================================
	// crystal clock enable divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_reg <= '0;
		else if (div_reg >= 16'(XTAL_DIV - 1))
			div_reg <= '0;
		else
			div_reg <= div_reg + 16'h0001;
	end
	assign xtal_tick = div_reg == 16'h0000;
	lprs_recovery_counter #(
		.LONG_CYCLES(LONG_CYCLES),
		.SHORT_CYCLES(SHORT_CYCLES)
	) u_rec (
		.pclk(pclk),
		.presetn(presetn),
		.hold_clear(state_reg != LPRS_RECOVER), // [RQ10] [RQ6]
		.tick(xtal_tick),
		.short_sel(config_reg[CFG_SSR_BIT]), // [RQ9]
		.done(rec_done)
	);
	// ========================================
	// low-power sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= LPRS_RUN;
		else if (any_reset)
			state_reg <= LPRS_RUN; // [RQ8] [RQ4]
		else
		begin
			case (state_reg)
				LPRS_RUN:
					if (stop_exec)
						state_reg <= LPRS_STOP;
					else if (wait_exec)
						state_reg <= LPRS_WAIT;
				LPRS_WAIT:
					if (module_irq || (break_irq && emulation_mode))
						state_reg <= LPRS_RUN; // [RQ3] [RQ4]
				LPRS_STOP:
					if (module_irq)
						state_reg <= LPRS_RECOVER; // [RQ7]
				LPRS_RECOVER:
					if (rec_done)
						state_reg <= LPRS_RUN; // [RQ7] [RQ9]
				default:
					state_reg <= LPRS_RUN;
			endcase
		end
	end
	// stacking pulse in the first run cycle after interrupt wake from wait or end of recovery, one cycle after the exit condition
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			stack_reg <= 1'b0;
		else
			stack_reg <= !any_reset && ((state_reg == LPRS_WAIT && module_irq)
				|| (state_reg == LPRS_RECOVER && rec_done)); // [RQ3] [RQ7]
	end
	assign stack_start = stack_reg;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mask_clr_reg <= 1'b0;
		else
			mask_clr_reg <= state_reg == LPRS_RUN && (wait_exec || stop_exec); // [RQ1]
	end
	assign clear_int_mask = mask_clr_reg;
	assign cpu_clock_en = state_reg == LPRS_RUN; // [RQ2] [RQ6]
	assign periph_clock_en = state_reg == LPRS_RUN || state_reg == LPRS_WAIT; // [RQ2]
	assign core_clock_out = state_reg != LPRS_STOP && state_reg != LPRS_RECOVER; // [RQ6]
	assign crystal_clock_out = state_reg != LPRS_STOP; // [RQ6]
	assign watchdog_enable = !config_reg[CFG_WDD_BIT]; // [RQ5]
	// ========================================
	// break status flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			break_wait_reg <= 1'b0;
		else if (state_reg == LPRS_WAIT && break_irq && emulation_mode && !any_reset)
			break_wait_reg <= 1'b1; // [RQ4] [RQ12]
		else if (wr_en && paddr == BREAK_STATUS_ADDR && !pwdata[BES_WAIT_BIT])
			break_wait_reg <= 1'b0;
	end
	// ========================================
	// reset cause flags
	logic [7:0] cause_set;
	logic monitor_hit;
	assign monitor_hit = monitor_entry_event && vector_high == VECTOR_BLANK
		&& vector_low == VECTOR_BLANK && !irq_at_test_voltage; // [RQ17]
	always_comb
	begin
		cause_set = BYTE_ZERO;
		cause_set[RC_PIN_BIT] = pin_reset_event; // [RQ16]
		cause_set[RC_WDOG_BIT] = watchdog_reset_event;
		cause_set[RC_ILLEGAL_OPCODE_FLAG_BIT] = illegal_opcode_event;
		cause_set[RC_ILLEGAL_ADDR_FLAG_BIT] = illegal_fetch_event;
		cause_set[RC_LVI_BIT] = low_voltage_event;
		cause_set[RC_MON_BIT] = monitor_hit;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			reset_cause_reg <= RC_POR_VALUE;
		else if (por_event)
			reset_cause_reg <= RC_POR_VALUE | cause_set; // [RQ14]
		else if (rd_en && paddr == RESET_CAUSE_ADDR)
			reset_cause_reg <= cause_set; // [RQ13]
		else
			reset_cause_reg <= reset_cause_reg | cause_set; // [RQ15]
	end
	// ========================================
	// break clear enable and low-power configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			break_clear_en_reg <= 1'b0;
		else if (wr_en && paddr == BREAK_FLAG_CTRL_ADDR)
			break_clear_en_reg <= pwdata[BCE_BIT];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			config_reg <= 2'b00;
		else if (wr_en && paddr == LP_CTRL_ADDR)
			config_reg <= pwdata[1:0]; // [RQ11]
	end
	// flag clears pass outside break, or in break with enable set
	assign flag_clear_allow = flag_clear_request
		&& (!break_state || break_clear_en_reg); // [RQ18] [RQ19]
	// ========================================
	// read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (psel && !penable && !pwrite)
		begin
			prdata <= '0; // [RQ20]
			if (paddr == BREAK_STATUS_ADDR)
				prdata[BES_WAIT_BIT] <= break_wait_reg; // [RQ12]
			else if (paddr == RESET_CAUSE_ADDR)
				prdata[7:0] <= reset_cause_reg;
			else if (paddr == BREAK_FLAG_CTRL_ADDR)
				prdata[BCE_BIT] <= break_clear_en_reg;
			else if (paddr == LP_CTRL_ADDR)
				prdata[1:0] <= config_reg;
			else if (paddr == LP_STATUS_ADDR)
				prdata[1:0] <= state_reg;
		end
	end
endmodule

//--- verification/lprs_ctrl_props.sv
`timescale 1ns/100ps
// ========================================
// low-power control checker
module lprs_chk #(
	parameter int LONG_CYCLES = 4096,
	parameter int SHORT_CYCLES = 32,
	parameter int XTAL_DIV = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire logic module_irq,
	input wire logic por_event,
	input wire logic pin_reset_event,
	input wire logic flag_clear_request,
	input wire logic cpu_clock_en,
	input wire logic periph_clock_en,
	input wire logic core_clock_out,
	input wire logic crystal_clock_out,
	input wire logic clear_int_mask,
	input wire logic stack_start,
	input wire logic watchdog_enable,
	input wire logic flag_clear_allow
);
	logic [15:0] rec_cnt;
	wire rec = crystal_clock_out && !core_clock_out;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			rec_cnt <= 16'h0000;
		else if (rec)
			rec_cnt <= rec_cnt + 16'h0001;
		else
			rec_cnt <= 16'h0000;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence wake_s;
		cpu_clock_en && stack_start;
	endsequence
	sequence rec_end_s;
		rec ##1 cpu_clock_en;
	endsequence
	mask_clear_a: assert property (cpu_clock_en && (wait_exec || stop_exec) |=> clear_int_mask)
		else $error("mask not cleared");
	wait_gate_a: assert property (cpu_clock_en && wait_exec && !stop_exec |=> !cpu_clock_en && periph_clock_en)
		else $error("wait gating wrong");
	wait_wake_a: assert property (!cpu_clock_en && periph_clock_en && module_irq |=> wake_s)
		else $error("wait wake wrong");
	watchdog_on_a: assert property (cpu_clock_en && wait_exec && watchdog_enable |=> watchdog_enable [*4])
		else $error("watchdog dropped");
	stop_gate_a: assert property (cpu_clock_en && stop_exec |=> !core_clock_out && !crystal_clock_out && !periph_clock_en)
		else $error("stop gating wrong");
	rec_length_a: assert property (rec_end_s |-> rec_cnt >= SHORT_CYCLES * XTAL_DIV - 2 && rec_cnt <= LONG_CYCLES * XTAL_DIV + 2)
		else $error("recovery length wrong");
	rec_stack_a: assert property (rec_end_s |-> stack_start)
		else $error("no stacking after recovery");
	reset_exit_a: assert property (por_event || pin_reset_event |=> cpu_clock_en && core_clock_out)
		else $error("reset did not exit");
	flag_gate_a: assert property (flag_clear_allow |-> flag_clear_request)
		else $error("clear without request");
endmodule
bind lprs_ctrl lprs_chk #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES),
	.XTAL_DIV(XTAL_DIV)) lprs_chk_i (.*);

//--- verification/lprs_cpu_model.sv
`timescale 1ns/100ps
// ========================================
// cpu core model
module lprs_cpu_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run_wait,
	input wire logic run_stop,
	input wire logic raise_irq,
	input wire logic cpu_clock_en,
	input wire logic clear_int_mask,
	input wire logic stack_start,
	output logic wait_exec,
	output logic stop_exec,
	output logic module_irq,
	output logic int_mask
);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			wait_exec <= 1'h0;
			stop_exec <= 1'h0;
			module_irq <= 1'h0;
			int_mask <= 1'h1;
		end
		else
		begin
			wait_exec <= run_wait && cpu_clock_en;
			stop_exec <= run_stop && cpu_clock_en;
			if (raise_irq)
				module_irq <= 1'h1;
			else if (stack_start)
				module_irq <= 1'h0;
			if (clear_int_mask)
				int_mask <= 1'h0;
			else if (stack_start)
				int_mask <= 1'h1;
		end
endmodule

//--- verification/test_low_power_and_reset_status_ctrl.sv
`timescale 1ns/100ps
// ========================================
// low-power and reset status bench
module test_low_power_and_reset_status_ctrl;
	import lprs_pkg::*;
	localparam int LONG = 64;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, e;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, wait_exec, stop_exec, module_irq, int_mask, por_event;
	logic break_irq = 1'h0, emulation_mode = 1'h1, break_state = 1'h0, flag_clear_request = 1'h0;
	logic pin_reset_event, watchdog_reset_event, illegal_opcode_event, illegal_fetch_event;
	logic low_voltage_event, monitor_entry_event, irq_at_test_voltage = 1'h0;
	logic [6:0] ev = '0;
	logic [7:0] vector_high = 8'hff, vector_low = 8'hff;
	logic cpu_clock_en, periph_clock_en, core_clock_out, crystal_clock_out;
	logic clear_int_mask, stack_start, watchdog_enable, flag_clear_allow;
	logic run_wait = 1'h0, run_stop = 1'h0, raise_irq = 1'h0;
	int n_fail = 0, compares = 0, n;
	assign {por_event, pin_reset_event, watchdog_reset_event, illegal_opcode_event,
		illegal_fetch_event, low_voltage_event, monitor_entry_event} = ev;
	always #12.5 pclk = ~pclk;
	lprs_ctrl #(.LONG_CYCLES(LONG)) lprs_ctrl_i (.*);
	lprs_cpu_model lprs_cpu_model_i (.pclk(pclk), .presetn(presetn), .run_wait(run_wait),
		.run_stop(run_stop), .raise_irq(raise_irq), .cpu_clock_en(cpu_clock_en),
		.clear_int_mask(clear_int_mask), .stack_start(stack_start), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .module_irq(module_irq), .int_mask(int_mask));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	task automatic give_up;
		n_fail++;
		wrap_up;
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int k;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		for (k = 0; pready !== 1'h1 && k < 20; k++)
			@(posedge pclk);
		if (k == 20)
			give_up;
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(q, x);
	endtask
	task automatic pulse(input logic [6:0] v);
		ev <= v;
		tick(1);
		ev <= 7'h00;
		tick(1);
	endtask
	task automatic enter(input logic s);
		{run_stop, run_wait} <= {s, !s};
		tick(1);
		{run_stop, run_wait} <= 2'h0;
		tick(3);
	endtask
	task automatic wait_stack;
		for (n = 0; stack_start !== 1'h1; n++)
		begin
			if (n == 400)
				give_up;
			@(posedge pclk);
		end
	endtask
	task automatic t_regs;
		rd(RESET_CAUSE_ADDR, 32'h80);
		rd(RESET_CAUSE_ADDR, 32'h00);
		pulse(7'h20);
		pulse(7'h1f);
		rd(RESET_CAUSE_ADDR, 32'h7e);
		pulse(7'h20);
		pulse(7'h40);
		rd(RESET_CAUSE_ADDR, 32'h80);
		rd(BREAK_STATUS_ADDR, 32'h00);
		apb(1'h1, BREAK_FLAG_CTRL_ADDR, 32'hffffffff);
		rd(BREAK_FLAG_CTRL_ADDR, 32'h80);
		apb(1'h0, 18'h3f808, 32'h0);
		chk({q[30:0], e}, 32'h1);
	endtask
	task automatic t_flag(input logic [31:0] ctl);
		apb(1'h1, BREAK_FLAG_CTRL_ADDR, ctl);
		break_state <= 1'h1;
		flag_clear_request <= 1'h1;
		tick(1);
		chk(flag_clear_allow, ctl[7]);
		flag_clear_request <= 1'h0;
		break_state <= 1'h0;
		tick(1);
	endtask
	task automatic t_wait(input logic brk);
		enter(1'h0);
		chk({cpu_clock_en, periph_clock_en, watchdog_enable, int_mask}, 4'h6);
		break_irq <= brk;
		raise_irq <= !brk;
		tick(1);
		raise_irq <= 1'h0;
		if (brk)
		begin
			tick(2);
			break_irq <= 1'h0;
			chk(cpu_clock_en, 1'h1);
			rd(BREAK_STATUS_ADDR, 32'h2);
			apb(1'h1, BREAK_STATUS_ADDR, 32'h0);
			rd(BREAK_STATUS_ADDR, 32'h0);
		end
		else
		begin
			wait_stack;
			chk(n >= 1 && n <= 2, 1'h1);
		end
	endtask
	task automatic t_stop(input logic [31:0] ctl, input int ticks);
		apb(1'h1, LP_CTRL_ADDR, ctl);
		enter(1'h1);
		chk({cpu_clock_en, periph_clock_en, core_clock_out, crystal_clock_out, int_mask}, 5'h0);
		raise_irq <= 1'h1;
		tick(1);
		raise_irq <= 1'h0;
		wait_stack;
		chk(n >= CRYSTAL_DIV * ticks && n <= CRYSTAL_DIV * ticks + 6, 1'h1);
	endtask
	initial
	begin
		tick(5);
		presetn <= 1'h1;
		tick(1);
		t_regs;
		t_flag(32'h0);
		t_flag(32'h80);
		t_wait(1'h0);
		t_wait(1'h1);
		t_stop(32'h1, SHORT_RECOVERY);
		t_stop(32'h0, LONG);
		enter(1'h1);
		pulse(7'h20);
		chk(cpu_clock_en, 1'h1);
		wrap_up;
	end
endmodule
